// >>> tb/bus_slave_model.sv
// Bus slave model standing for peripherals and memory
`timescale 1ns/10ps
module bus_slave_model
    import dma_chan_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire mreq_t      mreq,
    input wire logic [1:0] wait_cycles,
    input wire logic       err_inject,
    output mrsp_t          mrsp
);
    logic [1:0] waited;

    // Read data toggles outside answers so stale values never match
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mrsp   <= '0;
            waited <= 2'h0;
        end
        else if (mreq.valid && !mrsp.ready && waited == wait_cycles)
        begin
            mrsp.ready <= 1'b1;
            mrsp.err   <= err_inject;
            mrsp.rdata <= mreq.addr ^ 32'h5A5A_0000;
            waited     <= 2'h0;
        end
        else
        begin
            mrsp.ready <= 1'b0;
            mrsp.err   <= 1'b0;
            mrsp.rdata <= ~mrsp.rdata;
            waited     <= (mreq.valid && !mrsp.ready) ? waited + 2'h1 : 2'h0;
        end
    end
endmodule

// >>> tb/dma_chan_checker.sv
// Bus and completion checker for the DMA channel core
`timescale 1ns/10ps
module dma_chan_checker
    import dma_chan_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire reg_req_t          reg_req,
    input wire logic [31:0]       reg_rdata,
    input wire logic [NUM_CH-1:0] periph_req,
    input wire logic [NUM_CH-1:0] chan_done,
    input wire mreq_t             mreq,
    input wire mrsp_t             mrsp,
    input wire logic [NUM_CH-1:0] chan_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence fetch_end_s;
        mreq.valid && !mreq.write && mrsp.ready && !mrsp.err;
    endsequence
    sequence store_end_s;
        mreq.valid && mreq.write && mrsp.ready && !mrsp.err;
    endsequence

    req_hold_a: assert property (
        mreq.valid && !mrsp.ready |=> mreq.valid && $stable(mreq))
        else $error("bus request changed before ready");
    store_next_a: assert property (
        fetch_end_s |=> mreq.valid && mreq.write && mreq.wdata == $past(mrsp.rdata))
        else $error("store missing or data differs from fetch");
    done_pulse_a: assert property (
        store_end_s |=> chan_done != '0 && !mreq.valid)
        else $error("no completion after store");
    done_cause_a: assert property (
        chan_done != '0 |-> $onehot(chan_done) && $past(mreq.valid) && $past(mreq.write)
            && $past(mrsp.ready) && !$past(mrsp.err))
        else $error("completion without store");
    half_align_a: assert property (
        mreq.valid && mreq.size == SIZE_16 |-> !mreq.addr[0])
        else $error("halfword access misaligned");
    word_align_a: assert property (
        mreq.valid && mreq.size == SIZE_32 |-> mreq.addr[1:0] == 2'h0)
        else $error("word access misaligned");
    size_legal_a: assert property (
        mreq.valid |-> mreq.size != 2'h3)
        else $error("reserved item size on bus");
    err_stop_a: assert property (
        mreq.valid && mrsp.ready && mrsp.err |=> !mreq.valid && chan_done == '0)
        else $error("access continued after bus error");
endmodule

// >>> tb/dma_chan_core_tb.sv
// Self-checking testbench for the DMA channel core
`timescale 1ns/10ps
module dma_chan_core_tb;
    import dma_chan_pkg::*;
    localparam logic [31:0] PBV = 32'h1000_0003;
    localparam logic [31:0] MBV = 32'h2000_0007;
    logic              sys_clk;
    logic              rst_n;
    reg_req_t          reg_req;
    logic [31:0]       reg_rdata;
    logic [NUM_CH-1:0] periph_req;
    logic [NUM_CH-1:0] chan_done;
    mreq_t             mreq;
    mrsp_t             mrsp;
    logic [NUM_CH-1:0] chan_irq;
    logic [1:0]        wait_cycles;
    logic              err_inject;
    mreq_t             last_f;
    mreq_t             last_s;
    int                num_errors;
    int                total_checks;
    int                cycles;
    int                n_acc;

    dma_chan_core dma_chan_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .periph_req(periph_req), .chan_done(chan_done),
        .mreq(mreq), .mrsp(mrsp), .chan_irq(chan_irq));
    bus_slave_model bus_slave_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .mreq(mreq),
        .wait_cycles(wait_cycles), .err_inject(err_inject), .mrsp(mrsp));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Access log and hang guard
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (rst_n && mreq.valid && mrsp.ready)
        begin
            n_acc <= n_acc + 1;
            if (mreq.write)
                last_s <= mreq;
            else
                last_f <= mreq;
        end
        if (cycles == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic ik(input string nm, input logic e);
        chk(nm, {31'h0, e}, {31'h0, chan_irq[0]});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        reg_req.wr    <= 1'b1;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rck(input logic [7:0] a, input string nm, input logic [31:0] e);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.rd   <= 1'b1;
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask

    function automatic logic [31:0] al(input logic [31:0] a, input logic [1:0] s);
        return (s == SIZE_32) ? {a[31:2], 2'h0} : (s == SIZE_16) ? {a[31:1], 1'b0} : a;
    endfunction

    // One item on channel 0, request dropped once the fetch starts
    task automatic item();
        @(posedge sys_clk);
        periph_req[0] <= 1'b1;
        repeat (20)
        begin
            @(posedge sys_clk);
            if (mreq.valid)
                break;
        end
        periph_req[0] <= 1'b0;
        repeat (20)
        begin
            @(posedge sys_clk);
            if (!mreq.valid)
                break;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic setup(input logic [31:0] ctl, input logic [31:0] cnt);
        wr(OFS_CTL0, RST_WORD);
        wr(OFS_CLEAR, 32'h1);
        wr(OFS_CNT0, cnt);
        wr(OFS_PBASE0, PBV);
        wr(OFS_MBASE0, MBV);
        wr(OFS_CTL0, ctl);
    endtask

    task automatic t_reset();
        rck(OFS_CTL0, "ctl0", RST_WORD);
        rck(OFS_PBASE0, "pbase0", RST_WORD);
        rck(OFS_MBASE0 + 8'h50, "mbase4", RST_WORD);
        wr(8'hFC, 32'hFFFF_FFFF);
        rck(8'hFC, "unmapped", RST_WORD);
        wr(OFS_CNT0, 32'hFFFF_1234);
        rck(OFS_CNT0, "cnt width", 32'h0000_1234);
    endtask

    task automatic t_xfer(input logic d, input logic [1:0] s);
        logic [1:0]  ms;
        logic [31:0] ctl;
        int          n0;
        ms  = (s == SIZE_32) ? SIZE_8 : s + 2'h1;
        ctl = {20'h0, ms, s, 3'h0, d, 4'h3};
        setup(ctl, 32'h2);
        wr(OFS_CNT0, 32'h9);
        wr(OFS_PBASE0, RST_WORD);
        wr(OFS_CTL0, ctl ^ 32'h10);
        rck(OFS_CNT0, "cnt locked", 32'h2);
        rck(OFS_CTL0, "dir locked", ctl);
        item();
        chk("fetch addr", d ? al(MBV, ms) : al(PBV, s), last_f.addr);
        chk("store addr", d ? al(PBV, s) : al(MBV, ms), last_s.addr);
        chk("fetch size", {30'h0, d ? ms : s}, {30'h0, last_f.size});
        rck(OFS_CNT0, "cnt dec", 32'h1);
        rck(OFS_FLAGS, "half flags", 32'h5);
        ik("half irq gated", 1'b0);
        item();
        rck(OFS_FLAGS, "full flags", 32'h7);
        ik("full irq", 1'b1);
        n0 = n_acc;
        item();
        chk("zero cnt idle", n0, n_acc);
        wr(OFS_CLEAR, 32'h1);
        rck(OFS_FLAGS, "cleared", RST_WORD);
        ik("irq cleared", 1'b0);
    endtask

    task automatic t_circ();
        int n0;
        wait_cycles <= 2'h2;
        setup(32'h0000_0021, 32'h2);
        item();
        item();
        rck(OFS_CNT0, "reload", 32'h2);
        n0 = n_acc;
        item();
        chk("circ runs", n0 + 2, n_acc);
        wait_cycles <= 2'h0;
    endtask

    task automatic t_err();
        int n0;
        setup(32'h0000_0001, 32'h3);
        err_inject <= 1'b1;
        item();
        err_inject <= 1'b0;
        rck(OFS_FLAGS, "err flags", 32'h9);
        ik("err irq gated", 1'b0);
        rck(OFS_CTL0, "err stops", RST_WORD);
        wr(OFS_CTL0, 32'h0000_0008);
        rck(OFS_CTL0, "err gate", 32'h0000_0008);
        ik("err irq", 1'b1);
        n0 = n_acc;
        item();
        chk("off idle", n0, n_acc);
    endtask

    // Memory-to-memory run with stepping word addresses, no request needed
    task automatic t_m2m();
        int n0;
        n0 = n_acc;
        setup(32'h0000_4AC3, 32'h2);
        repeat (20) @(posedge sys_clk);
        chk("m2m runs", n0 + 4, n_acc);
        chk("fetch step", al(PBV, SIZE_32) + 32'h4, last_f.addr);
        chk("store step", al(MBV, SIZE_32) + 32'h4, last_s.addr);
        rck(OFS_CNT0, "m2m cnt", RST_WORD);
        rck(OFS_FLAGS, "m2m flags", 32'h7);
        ik("m2m full irq", 1'b1);
    endtask

    // Reset after the memory-to-memory run, channel still on, returns registers and outputs to zero
    task automatic t_rst();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("irq after reset", RST_WORD, {27'h0, chan_irq});
        rck(OFS_CNT0, "cnt after reset", RST_WORD);
        rck(OFS_FLAGS, "flags after reset", RST_WORD);
        rck(OFS_CTL0, "ctl after reset", RST_WORD);
    endtask

    initial
    begin
        rst_n       = 1'b0;
        reg_req     = '0;
        periph_req  = '0;
        wait_cycles = 2'h0;
        err_inject  = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        for (int d = 0; d < 2; d++)
            for (int s = 0; s < 3; s++)
                t_xfer(d[0], s[1:0]);
        t_circ();
        t_err();
        t_m2m();
        t_rst();
        end_of_test();
    end
endmodule

bind dma_chan_core dma_chan_checker dma_chan_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .chan_done(chan_done), .mreq(mreq), .mrsp(mrsp), .chan_irq(chan_irq));

// >>> verilog/dma_chan_core.sv
// Five-channel DMA transfer setup, bookkeeping and bus engine
//
// Summary of operation
// - Direction 0 fetches peripheral, stores memory; 1 fetches memory, stores peripheral.
// - Direction bit writes are ignored while the channel is on.
// - Error flag requests an interrupt only while the error gate is set.
// - Half-done flag requests an interrupt only while its gate is set.
// - Full-done flag requests an interrupt only while its gate is set.
// - Remaining count is 16 bits; upper counter bits read zero.
// - Remaining count is read-only while the channel is on.
// - Count drops by one after every completed item.
// - A channel with zero count issues no bus transaction.
// - Circular mode reloads the programmed count at run end and continues.
// - Counter and both base registers ignore writes while channel is on.
// - 16-bit peripheral items drop peripheral address bit 0.
// - 32-bit peripheral items drop peripheral address bits 1:0.
// - 16-bit memory items drop memory address bit 0.
// - 32-bit memory items drop memory address bits 1:0.
// - Item size 00 is 8-bit, 01 16-bit, 10 32-bit, 11 reserved.
// - Any-event flag is set while error, half or full flag is set.
// - Any-event clear bit clears all four flags of the channel.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

module dma_chan_core
    import dma_chan_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire reg_req_t          reg_req,
    output logic [31:0]            reg_rdata,
    input  wire logic [NUM_CH-1:0] periph_req,
    output logic [NUM_CH-1:0]      chan_done,
    output mreq_t                  mreq,
    input  wire mrsp_t             mrsp,
    output logic [NUM_CH-1:0]      chan_irq
);

    state_t s;
    state_t next_s;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] align_addr(input logic [31:0] a,
                                               input logic [1:0]  size);
        logic [31:0] r;
        r = a;
        if (size == SIZE_16)
        begin
            r[0] = 1'b0;
        end
        else if (size == SIZE_32)
        begin
            r[1:0] = 2'h0;
        end
        return r;
    endfunction

    function automatic logic [31:0] step_addr(input logic [31:0] a,
                                              input logic [1:0]  size,
                                              input logic        inc);
        logic [31:0] r;
        r = a;
        if (inc)
        begin
            unique case (size)
                SIZE_16: r = a + 32'h0000_0002;
                SIZE_32: r = a + 32'h0000_0004;
                default: r = a + 32'h0000_0001;
            endcase
        end
        return r;
    endfunction

    function automatic logic [7:0] ch_ofs(input logic [7:0] base, input int i);
        return base + 8'(CH_STRIDE * i);
    endfunction

    function automatic logic [1:0] psize(input chan_t c);
        return c.ctl[CTL_PSIZE+:2];
    endfunction

    function automatic logic [1:0] msize(input chan_t c);
        return c.ctl[CTL_MSIZE+:2];
    endfunction

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign mreq      = s.mreq;
    assign chan_done = s.done;

    generate
        for (genvar g = 0; g < NUM_CH; g++)
        begin : g_irq
            assign chan_irq[g] = (s.ch[g].err  & s.ch[g].ctl[CTL_ERR_IE])
                               | (s.ch[g].half & s.ch[g].ctl[CTL_HALF_IE])
                               | (s.ch[g].full & s.ch[g].ctl[CTL_FULL_IE]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [14:0] mask;
        logic [14:0] nctl;
        logic [15:0] left;
        logic        found;
        logic        dir;
        chan_t       c;
        mask   = CTL_ALL_MASK;
        nctl   = '0;
        left   = CNT_ZERO;
        found  = 1'b0;
        dir    = 1'b0;
        c      = s.ch[s.sel];
        next_s = s;
        next_s.rdata = RST_WORD;
        next_s.done  = '0;

        // Register reads, one cycle later
        if (reg_req.rd)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (reg_req.addr == OFS_FLAGS)
                begin
                    next_s.rdata[FLG_STRIDE*i+FLG_ANY]  = s.ch[i].err | s.ch[i].half
                                                        | s.ch[i].full;
                    next_s.rdata[FLG_STRIDE*i+FLG_FULL] = s.ch[i].full;
                    next_s.rdata[FLG_STRIDE*i+FLG_HALF] = s.ch[i].half;
                    next_s.rdata[FLG_STRIDE*i+FLG_ERR]  = s.ch[i].err;
                end
                if (reg_req.addr == ch_ofs(OFS_CTL0, i))
                begin
                    next_s.rdata[14:0] = s.ch[i].ctl;
                end
                if (reg_req.addr == ch_ofs(OFS_CNT0, i))
                begin
                    next_s.rdata[15:0] = s.ch[i].count;
                end
                if (reg_req.addr == ch_ofs(OFS_PBASE0, i))
                begin
                    next_s.rdata = s.ch[i].pbase;
                end
                if (reg_req.addr == ch_ofs(OFS_MBASE0, i))
                begin
                    next_s.rdata = s.ch[i].mbase;
                end
            end
        end

        // Register writes
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (reg_req.wr && reg_req.addr == ch_ofs(OFS_CTL0, i))
            begin
                mask = s.ch[i].ctl[CTL_ON] ? CTL_LIVE_MASK : CTL_ALL_MASK;
                nctl = (reg_req.wdata[14:0] & mask) | (s.ch[i].ctl & ~mask);
                next_s.ch[i].ctl = nctl;
                // Start of a run latches aligned working addresses
                if (!s.ch[i].ctl[CTL_ON] && nctl[CTL_ON])
                begin
                    next_s.ch[i].pcur = align_addr(s.ch[i].pbase,
                                                   nctl[CTL_PSIZE+:2]);
                    next_s.ch[i].mcur = align_addr(s.ch[i].mbase,
                                                   nctl[CTL_MSIZE+:2]);
                end
            end
            if (!s.ch[i].ctl[CTL_ON] && reg_req.wr)
            begin
                if (reg_req.addr == ch_ofs(OFS_CNT0, i))
                begin
                    next_s.ch[i].count  = reg_req.wdata[15:0];
                    next_s.ch[i].reload = reg_req.wdata[15:0];
                end
                if (reg_req.addr == ch_ofs(OFS_PBASE0, i))
                begin
                    next_s.ch[i].pbase = reg_req.wdata;
                end
                if (reg_req.addr == ch_ofs(OFS_MBASE0, i))
                begin
                    next_s.ch[i].mbase = reg_req.wdata;
                end
            end
            if (reg_req.wr && reg_req.addr == OFS_CLEAR)
            begin
                if (reg_req.wdata[FLG_STRIDE*i+FLG_ANY])
                begin
                    next_s.ch[i].err  = 1'b0;
                    next_s.ch[i].half = 1'b0;
                    next_s.ch[i].full = 1'b0;
                end
                if (reg_req.wdata[FLG_STRIDE*i+FLG_ERR])
                begin
                    next_s.ch[i].err = 1'b0;
                end
                if (reg_req.wdata[FLG_STRIDE*i+FLG_HALF])
                begin
                    next_s.ch[i].half = 1'b0;
                end
                if (reg_req.wdata[FLG_STRIDE*i+FLG_FULL])
                begin
                    next_s.ch[i].full = 1'b0;
                end
            end
        end

        // Transfer engine; flag sets below win over the clears above
        dir = c.ctl[CTL_DIR];
        unique case (s.phase)
            ST_IDLE:
            begin
                for (int i = NUM_CH - 1; i >= 0; i--)
                begin
                    if (s.ch[i].ctl[CTL_ON] && s.ch[i].count != CNT_ZERO
                        && (periph_req[i] || s.ch[i].ctl[CTL_M2M]))
                    begin
                        found = 1'b1;
                        next_s.sel = 3'(i);
                    end
                end
                if (found)
                begin
                    c   = s.ch[next_s.sel];
                    dir = c.ctl[CTL_DIR];
                    next_s.mreq.valid = 1'b1;
                    next_s.mreq.write = 1'b0;
                    next_s.mreq.addr  = dir ? c.mcur : c.pcur;
                    next_s.mreq.size  = dir ? msize(c) : psize(c);
                    next_s.phase      = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (mrsp.ready)
                begin
                    if (mrsp.err)
                    begin
                        next_s.mreq.valid            = 1'b0;
                        next_s.ch[s.sel].err         = 1'b1;
                        next_s.ch[s.sel].ctl[CTL_ON] = 1'b0;
                        next_s.phase                 = ST_IDLE;
                    end
                    else
                    begin
                        next_s.mreq.write = 1'b1;
                        next_s.mreq.wdata = mrsp.rdata;
                        next_s.mreq.addr  = dir ? c.pcur : c.mcur;
                        next_s.mreq.size  = dir ? psize(c) : msize(c);
                        next_s.phase      = ST_STORE;
                    end
                end
            end
            ST_STORE:
            begin
                if (mrsp.ready)
                begin
                    next_s.mreq.valid = 1'b0;
                    next_s.mreq.write = 1'b0;
                    next_s.phase      = ST_IDLE;
                    if (mrsp.err)
                    begin
                        next_s.ch[s.sel].err         = 1'b1;
                        next_s.ch[s.sel].ctl[CTL_ON] = 1'b0;
                    end
                    else
                    begin
                        left = c.count - CNT_ONE;
                        next_s.done[s.sel]    = 1'b1;
                        next_s.ch[s.sel].count = left;
                        next_s.ch[s.sel].pcur = step_addr(c.pcur, psize(c), c.ctl[CTL_PINC]);
                        next_s.ch[s.sel].mcur = step_addr(c.mcur, msize(c), c.ctl[CTL_MINC]);
                        if (left == (c.reload >> 1))
                        begin
                            next_s.ch[s.sel].half = 1'b1;
                        end
                        if (left == CNT_ZERO)
                        begin
                            next_s.ch[s.sel].full = 1'b1;
                            if (c.ctl[CTL_CIRC])
                            begin
                                next_s.ch[s.sel].count = c.reload;
                                next_s.ch[s.sel].pcur  = align_addr(c.pbase, psize(c));
                                next_s.ch[s.sel].mcur  = align_addr(c.mbase, msize(c));
                            end
                        end
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s       <= '0;
            s.phase <= ST_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// >>> verilog/dma_chan_pkg.sv
// Constants, field layouts and carrier types of the DMA channel block
package dma_chan_pkg;

    localparam int          NUM_CH     = 5;
    localparam logic [7:0]  OFS_FLAGS  = 8'h00;
    localparam logic [7:0]  OFS_CLEAR  = 8'h04;
    localparam logic [7:0]  OFS_CTL0   = 8'h08;
    localparam logic [7:0]  OFS_CNT0   = 8'h0C;
    localparam logic [7:0]  OFS_PBASE0 = 8'h10;
    localparam logic [7:0]  OFS_MBASE0 = 8'h14;
    localparam logic [7:0]  CH_STRIDE  = 8'h14;

    // Control bit positions
    localparam int CTL_ON      = 0;
    localparam int CTL_FULL_IE = 1;
    localparam int CTL_HALF_IE = 2;
    localparam int CTL_ERR_IE  = 3;
    localparam int CTL_DIR     = 4;
    localparam int CTL_CIRC    = 5;
    localparam int CTL_PINC    = 6;
    localparam int CTL_MINC    = 7;
    localparam int CTL_PSIZE   = 8;
    localparam int CTL_MSIZE   = 10;
    localparam int CTL_M2M     = 14;
    localparam logic [14:0] CTL_ALL_MASK  = 15'h7FFF;
    localparam logic [14:0] CTL_LIVE_MASK = 15'h000F;

    // Flag bit positions inside one channel nibble
    localparam int FLG_ANY    = 0;
    localparam int FLG_FULL   = 1;
    localparam int FLG_HALF   = 2;
    localparam int FLG_ERR    = 3;
    localparam int FLG_STRIDE = 4;

    localparam logic [1:0]  SIZE_8    = 2'h0;
    localparam logic [1:0]  SIZE_16   = 2'h1;
    localparam logic [1:0]  SIZE_32   = 2'h2;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_ONE   = 16'h0001;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_STORE = 3'b100
    } phase_t;

    typedef struct packed {
        logic [14:0] ctl;
        logic [15:0] count;
        logic [15:0] reload;
        logic [31:0] pbase;
        logic [31:0] mbase;
        logic [31:0] pcur;
        logic [31:0] mcur;
        logic        err;
        logic        half;
        logic        full;
    } chan_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mreq_t;

    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } mrsp_t;

    typedef struct packed {
        chan_t [NUM_CH-1:0] ch;
        phase_t             phase;
        logic [2:0]         sel;
        logic [NUM_CH-1:0]  done;
        logic [31:0]        rdata;
        mreq_t              mreq;
    } state_t;

endpackage
